// ---- hmvt_pkg.sv ----
// Package for the host MAC tag detector and wake filter loader
package hmvt_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_FIRST_TAG = 4'h9;
	localparam logic [3:0] IDX_SECOND_TAG = 4'ha;
	localparam logic [3:0] IDX_WAKE_LOADER = 4'hb;
	localparam logic [3:0] IDX_RX_STATUS = 4'hc;
	localparam logic [15:0] TAG_RESET = 16'hffff;
	localparam int TAG_MSB = 15;
	// Frame length limits in bytes
	localparam logic [11:0] LEN_PLAIN = 12'h5ee;
	localparam logic [11:0] LEN_FIRST = 12'h5f2;
	localparam logic [11:0] LEN_SECOND = 12'h602;
	// Byte positions of the tag field, counted from zero
	localparam logic [11:0] TAG_BYTE_HI = 12'h00c;
	localparam logic [11:0] TAG_BYTE_LO = 12'h00d;
	localparam int FILTER_WORDS = 8;
	localparam logic [2:0] FILTER_PTR_RESET = 3'h0;
	// Frame classification
	typedef enum logic [2:0] {
		CLS_PLAIN = 3'b001,
		CLS_FIRST = 3'b010,
		CLS_SECOND = 3'b100
	} hmvt_cls_t;
	// Received byte stream from the fabric
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [7:0] data;
	} hmvt_rx_t;
	// Per-frame verdict
	typedef struct packed {
		logic done;
		logic too_long;
		hmvt_cls_t cls;
		logic [11:0] limit;
	} hmvt_verdict_t;
endpackage

// ---- hmvt_filter_store.sv ----
// Eight-word wake filter store with auto-advancing write pointer
`timescale 1ns/1ps
module hmvt_filter_store
	import hmvt_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic wr, // One-cycle write strobe
	input wire logic [31:0] wdata, // Word to store
	input wire logic [2:0] rd_idx, // Word select for the pattern matcher
	output logic [31:0] rd_word, // Selected filter word
	output logic [2:0] ptr // Next word to be written
);
	logic [31:0] mem [FILTER_WORDS];
	logic [2:0] next_ptr;

	// Pointer advance, wraps after the last word
	always_comb
	begin
		next_ptr = ptr;
		if (wr)
			next_ptr = ptr + 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ptr <= FILTER_PTR_RESET;
		else
			ptr <= next_ptr;
	end

	// Words have no reset value
	always_ff @(posedge pclk)
	begin
		if (wr)
			mem[ptr] <= wdata;
		rd_word <= mem[rd_idx];
	end
endmodule

// ---- hmvt_top.sv ----
// Tag detection, frame length limit and wake filter loading on APB
`timescale 1ns/1ps

// Functional notes
// (RULE_01) Compare first tag value with received bytes 13 and 14; match means first-type.
// (RULE_02) First-type frame raises length limit from 1518 to 1522 bytes.
// (RULE_03) Compare second tag value with bytes 13 and 14; match means second-type.
// (RULE_04) Second-type frame raises length limit from 1518 to 1538 bytes.
// (RULE_05) Equal tag values: first-type wins, limit 1522.
// (RULE_06) Software should use 8100h and keep the two values distinct.
// (RULE_07) Tag fields reset to FFFFh, read/write; upper sixteen bits read zero.
// (RULE_08) After reset first filter write lands in word 0, then next words.
// (RULE_09) After eighth word the write pointer wraps to word 0.
// (RULE_10) Filter loader location is write-only.
// (RULE_11) Reading the filter loader returns zero, pointer unchanged.
module hmvt_top
	import hmvt_pkg::*;
(
	input wire logic pclk, // APB clock, 40 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire hmvt_rx_t rx, // Received frame bytes
	input wire logic [2:0] filter_idx, // Filter word select for matcher
	output logic [31:0] filter_word, // Selected filter word
	output hmvt_verdict_t verdict // Frame verdict, valid with done
);
	logic [15:0] first_tag_value;
	logic [15:0] second_tag_value;
	logic [15:0] next_first_tag_value;
	logic [15:0] next_second_tag_value;
	logic [11:0] byte_cnt;
	logic [11:0] next_byte_cnt;
	logic [7:0] hi_byte;
	logic [7:0] next_hi_byte;
	hmvt_cls_t cls;
	hmvt_cls_t next_cls;
	hmvt_verdict_t next_verdict;
	hmvt_verdict_t last_verdict;
	hmvt_verdict_t next_last_verdict;
	logic [31:0] next_prdata;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic [3:0] idx;
	logic filter_wr;
	logic [2:0] filter_ptr;

	// Length limit for a class
	function automatic logic [11:0] limit_of(input hmvt_cls_t c);
		case (c)
			CLS_FIRST: limit_of = LEN_FIRST;
			CLS_SECOND: limit_of = LEN_SECOND;
			default: limit_of = LEN_PLAIN;
		endcase
	endfunction

	// APB decode; single-cycle access phase
	assign idx = paddr[5:2];
	assign acc = psel && penable;
	assign mapped = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0)
		&& (idx == IDX_FIRST_TAG || idx == IDX_SECOND_TAG
		|| idx == IDX_WAKE_LOADER || idx == IDX_RX_STATUS);
	assign wr_acc = acc && pwrite && mapped;
	assign rd_acc = acc && !pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	// (RULE_08) Writes feed the store
	assign filter_wr = wr_acc && idx == IDX_WAKE_LOADER;

	// Register writes and read mux
	always_comb
	begin
		next_first_tag_value = first_tag_value;
		next_second_tag_value = second_tag_value;
		next_prdata = prdata;
		// (RULE_07) Tag fields writable
		if (wr_acc && idx == IDX_FIRST_TAG)
			next_first_tag_value = pwdata[TAG_MSB:0];
		if (wr_acc && idx == IDX_SECOND_TAG)
			next_second_tag_value = pwdata[TAG_MSB:0];
		if (acc && !pwrite)
		begin
			next_prdata = 32'h0;
			// (RULE_07) Upper bits zero
			if (rd_acc && idx == IDX_FIRST_TAG)
				next_prdata = {16'h0, first_tag_value};
			else if (rd_acc && idx == IDX_SECOND_TAG)
				next_prdata = {16'h0, second_tag_value};
			else if (rd_acc && idx == IDX_RX_STATUS)
				next_prdata = {11'h0, filter_ptr, 1'b0, last_verdict.too_long,
					1'b0, last_verdict.cls, last_verdict.limit};
			// (RULE_11) Loader reads zero, no pointer move
			// (RULE_10) Write-only location
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// (RULE_07) Reset to FFFFh
			first_tag_value <= TAG_RESET;
			second_tag_value <= TAG_RESET;
		end
		else
		begin
			first_tag_value <= next_first_tag_value;
			second_tag_value <= next_second_tag_value;
		end
	end

	// Read data registered during setup so it stands in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_value(paddr);
		else
			prdata <= next_prdata;
	end

	// Read value for an address
	function automatic logic [31:0] rd_value(input logic [31:0] a);
		logic [3:0] i;
		i = a[5:2];
		rd_value = 32'h0;
		if (a[31:6] == 26'h0 && a[1:0] == 2'h0)
		begin
			if (i == IDX_FIRST_TAG)
				rd_value = {16'h0, first_tag_value};
			else if (i == IDX_SECOND_TAG)
				rd_value = {16'h0, second_tag_value};
			else if (i == IDX_RX_STATUS)
				rd_value = {11'h0, filter_ptr, 1'b0, last_verdict.too_long,
					1'b0, last_verdict.cls, last_verdict.limit};
		end
	endfunction

	// Frame byte counting and tag classification
	always_comb
	begin
		next_byte_cnt = byte_cnt;
		next_hi_byte = hi_byte;
		next_cls = cls;
		next_verdict = verdict;
		next_verdict.done = 1'b0;
		next_last_verdict = last_verdict;
		if (rx.valid)
		begin
			if (rx.sof)
			begin
				next_byte_cnt = 12'h1;
				next_cls = CLS_PLAIN;
			end
			else if (byte_cnt != 12'hfff)
				next_byte_cnt = byte_cnt + 12'h1;
			if (!rx.sof && byte_cnt == TAG_BYTE_HI)
				next_hi_byte = rx.data;
			if (!rx.sof && byte_cnt == TAG_BYTE_LO)
			begin
				// (RULE_05) First wins on equal values
				// (RULE_01) First tag compare
				if ({hi_byte, rx.data} == first_tag_value)
					next_cls = CLS_FIRST;
				// (RULE_03) Second tag compare
				else if ({hi_byte, rx.data} == second_tag_value)
					next_cls = CLS_SECOND;
				else
					next_cls = CLS_PLAIN;
			end
			if (rx.eof)
			begin
				next_verdict.done = 1'b1;
				next_verdict.cls = next_cls;
				// (RULE_02) (RULE_04) Limit per class
				next_verdict.limit = limit_of(next_cls);
				next_verdict.too_long = next_byte_cnt > limit_of(next_cls);
				next_last_verdict = next_verdict;
				next_last_verdict.done = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			byte_cnt <= 12'h0;
			hi_byte <= 8'h0;
			cls <= CLS_PLAIN;
			verdict <= '{done: 1'b0, too_long: 1'b0, cls: CLS_PLAIN, limit: LEN_PLAIN};
			last_verdict <= '{done: 1'b0, too_long: 1'b0, cls: CLS_PLAIN, limit: LEN_PLAIN};
		end
		else
		begin
			byte_cnt <= next_byte_cnt;
			hi_byte <= next_hi_byte;
			cls <= next_cls;
			verdict <= next_verdict;
			last_verdict <= next_last_verdict;
		end
	end

	// (RULE_09) Pointer wraps inside the store
	hmvt_filter_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.wr(filter_wr),
		.wdata(pwdata),
		.rd_idx(filter_idx),
		.rd_word(filter_word),
		.ptr(filter_ptr)
	);
endmodule

// ---- hmvt_monitor.sv ----
// Port checker for the tag detector and filter loader
`timescale 1ns/1ps
module hmvt_monitor
	import hmvt_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] paddr, // Address
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire hmvt_rx_t rx, // Frame bytes
	input wire hmvt_verdict_t verdict // Verdict
);
	logic [11:0] cnt;
	logic [11:0] next_cnt;
	logic acc;
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase
	assign acc = psel && penable;
	// Byte count of the current frame
	always_comb
	begin
		next_cnt = cnt;
		if (rx.valid)
			next_cnt = rx.sof ? 12'h001 : cnt + 12'h001;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 12'h000;
		else
			cnt <= next_cnt;
	end
	AST_TAG_UPPER: assert property (acc && !pwrite && paddr inside {32'h24, 32'h28}
		|-> prdata[31:16] == 16'h0) else $error("tag upper half set");
	AST_LOADER_ZERO: assert property (acc && !pwrite && paddr == 32'h2c
		|-> prdata == 32'h0 && !pslverr) else $error("loader read not zero");
	AST_FIRST_LIM: assert property (verdict.done && verdict.cls == CLS_FIRST
		|-> verdict.limit == LEN_FIRST) else $error("first limit wrong");
	AST_SECOND_LIM: assert property (verdict.done && verdict.cls == CLS_SECOND
		|-> verdict.limit == LEN_SECOND) else $error("second limit wrong");
	AST_PLAIN_LIM: assert property (verdict.done && verdict.cls == CLS_PLAIN
		|-> verdict.limit == LEN_PLAIN) else $error("plain limit wrong");
	AST_VERDICT_TIME: assert property (rx.valid && rx.eof |=> verdict.done)
		else $error("verdict late");
	AST_VERDICT_CAUSE: assert property (verdict.done |-> $past(rx.valid && rx.eof))
		else $error("verdict without frame end");
	AST_READY: assert property (acc |-> pready)
		else $error("access without ready");
	AST_TOO_LONG: assert property (verdict.done
		|-> verdict.too_long == (cnt > verdict.limit)) else $error("length verdict wrong");
endmodule

// ---- hmvt_fabric.sv ----
// Fabric model streaming received frames into the block
`timescale 1ns/1ps
module hmvt_fabric
	import hmvt_pkg::*;
(
	input wire logic pclk, // Clock
	output hmvt_rx_t rx // Frame bytes
);
	initial rx = '0;
	// tag at bytes 13, 14; random idle gaps, idle data toggles
	task send(input int len, input logic [15:0] tg);
		int i;
		for (i = 1; i <= len; i++)
		begin
			while ($urandom_range(3) == 0)
			begin
				rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
				@(posedge pclk);
			end
			rx <= '{1'b1, i == 1, i == len, i == 13 ? tg[15:8] : i == 14 ? tg[7:0] : 8'($urandom)};
			@(posedge pclk);
		end
		rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
	endtask
endmodule

// ---- hmvt_top_tb.sv ----
// Self-checking bench for the tag detector and filter loader
`timescale 1ns/1ps
module hmvt_top_tb
	import hmvt_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] filter_idx = 3'h0;
	logic [31:0] prdata, filter_word, r;
	logic pready, pslverr, e;
	hmvt_rx_t rx;
	hmvt_verdict_t verdict;
	int n_mismatch = 0;
	int tests_run = 0;
	int i;
	logic [15:0] t1, t2;
	logic [31:0] w [8];
	int fl [7] = '{1522, 1523, 1538, 1539, 1518, 1519, 13};
	int fs [7] = '{1, 1, 2, 2, 0, 0, 1};
	// Clock
	always #12.5 pclk = ~pclk;
	hmvt_top hmvt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx(rx), .filter_idx(filter_idx), .filter_word(filter_word),
		.verdict(verdict));
	hmvt_fabric hmvt_fabric_inst (.pclk(pclk), .rx(rx));
	task conclude;
		$display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task lost;
		n_mismatch++;
		$display("unexpected at %0t: timeout", $time);
		conclude();
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Bus transfer; read data and error land in r and e
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			rdy = pready;
			if (rdy === 1'b1)
			begin
				r = prdata;
				e = pslverr;
				break;
			end
		end
		if (k == 20)
			lost();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One frame against the model verdict
	task frame(input int len, input logic [15:0] tg);
		int cls, lim, k;
		cls = len < 14 ? 1 : tg == t1 ? 2 : tg == t2 ? 4 : 1;
		lim = cls == 2 ? 1522 : cls == 4 ? 1538 : 1518;
		@(posedge pclk);
		hmvt_fabric_inst.send(len, tg);
		k = 0;
		do
		begin
			@(negedge pclk);
			k++;
		end
		while (verdict.done !== 1'b1 && k < 40);
		if (verdict.done !== 1'b1)
			lost();
		chk({16'h0, verdict.too_long, verdict.cls, verdict.limit},
			{16'h0, len > lim, 3'(cls), 12'(lim)});
	endtask
	initial
	begin
		void'($urandom(32'h3eb1));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 32'h24, 32'h0);
		chk(r, 32'h0000ffff);
		apb(1'b0, 32'h28, 32'h0);
		chk(r, 32'h0000ffff);
		apb(1'b0, 32'h30, 32'h0);
		chk({29'h0, r[20:18]}, 32'h0);
		// standard first tag, distinct second tag
		t1 = 16'h8100;
		t2 = {8'h91, 8'($urandom)};
		apb(1'b1, 32'h24, 32'hffff8100);
		apb(1'b1, 32'h28, {16'hffff, t2});
		apb(1'b0, 32'h24, 32'h0);
		chk(r, 32'h00008100);
		for (i = 0; i < 7; i++)
			frame(fl[i], fs[i] == 1 ? t1 : fs[i] == 2 ? t2 : 16'h0800);
		// Equal tags favour the first type
		apb(1'b1, 32'h28, {16'h0, t1});
		t2 = t1;
		frame(1523, t1);
		// Nine loads wrap onto word 0
		for (i = 0; i < 9; i++)
		begin
			w[i % 8] = $urandom;
			apb(1'b1, 32'h2c, w[i % 8]);
		end
		apb(1'b0, 32'h2c, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 32'h30, 32'h0);
		chk({29'h0, r[20:18]}, 32'h1);
		for (i = 0; i < 8; i++)
		begin
			@(posedge pclk);
			filter_idx <= 3'(i);
			@(posedge pclk);
			@(negedge pclk);
			chk(filter_word, w[i]);
		end
		apb(1'b0, 32'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		conclude();
	end
endmodule
bind hmvt_top hmvt_monitor hmvt_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx(rx), .verdict(verdict));
